/* File: src/plic_core.v */
// Platform interrupt controller for one hart, with timer soft flag and trap vector
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`include "plic_defs.vh"
module plic_core #(
  parameter NSRC   = 31,
  parameter PRIO_W = 3
) (
  // Clock, reset, enable
  input  wire              clk,
  input  wire              rstn,
  input  wire              ce,
  // APB slave
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [11:0]       paddr,
  input  wire [31:0]       pwdata,
  output reg               pready,
  output reg  [31:0]       prdata,
  output reg               pslverr,
  // Interrupt sources
  input  wire [NSRC:1]     src_level,
  input  wire              timer_cmp_level,
  // Hart side
  output reg               ext_irq_r,
  output reg  [7:0]        ext_irq_id_r,
  output reg               soft_irq_r,
  output reg               timer_irq_r,
  output reg  [31:0]       trap_vector_r,
  output reg               ctrl_irq_r
);

  // Single hart; NSRC at most 31 so one word holds every enable bit
  reg  [PRIO_W-1:0] prio_r [1:NSRC];
  reg  [NSRC:1]     enable_r;
  reg  [NSRC:1]     pend_r;
  reg  [NSRC:1]     busy_r;
  reg  [PRIO_W-1:0] thresh_r;
  reg  [`EV_W-1:0]  istat_r;
  reg  [`EV_W-1:0]  ien_r;
  reg  [7:0]        claim_id_r;
  reg               claim_go_r;

  wire setup  = ce & psel & ~penable;
  wire access = ce & psel & penable & pready;
  wire wr_acc = access & pwrite;

  // One strobe per written register, all taken at the access edge
  function wr_at;
    input        acc;
    input [11:0] a;
    input [11:0] ofs;
    begin
      wr_at = acc && a == ofs;
    end
  endfunction

  wire wr_enable = wr_at(wr_acc, paddr, `ENABLE_OFS);
  wire wr_thresh = wr_at(wr_acc, paddr, `THRESH_OFS);
  wire wr_claim  = wr_at(wr_acc, paddr, `CLAIM_OFS);
  wire wr_soft   = wr_at(wr_acc, paddr, `SOFT_OFS);
  wire wr_tvec   = wr_at(wr_acc, paddr, `TVEC_OFS);
  wire wr_ien    = wr_at(wr_acc, paddr, `IEN_OFS);
  wire wr_iclr   = wr_at(wr_acc, paddr, `ICLR_OFS);

  // Source number held in a priority word, zero when not a priority address
  function [7:0] prio_index;
    input [11:0] a;
    begin
      prio_index = 8'h00;
      if (a[11:8] == 4'h0 && a[1:0] == 2'b00 && a[7:2] != 6'd0 && a[7:2] <= NSRC)
        prio_index = {2'b00, a[7:2]};
    end
  endfunction

  // Address is a defined register; priority words first, then the fixed map
  function mapped;
    input [11:0] a;
    begin
      if (prio_index(a) != 8'h00)
        mapped = 1'b1;
      else begin
        case (a)
          `ENABLE_OFS:  mapped = 1'b1;
          `PENDING_OFS: mapped = 1'b1;
          `THRESH_OFS:  mapped = 1'b1;
          `CLAIM_OFS:   mapped = 1'b1;
          `SOFT_OFS:    mapped = 1'b1;
          `TVEC_OFS:    mapped = 1'b1;
          `ISTAT_OFS:   mapped = 1'b1;
          `ICLR_OFS:    mapped = 1'b1;
          `IEN_OFS:     mapped = 1'b1;
          default:      mapped = 1'b0;
        endcase
      end
    end
  endfunction

  // Best candidate, threshold deliberately not used here
  reg [7:0]        best_id;
  reg [PRIO_W-1:0] best_prio;
  // Priority zero never beats the zero start, so it acts as disabled
  integer k;
  always @* begin
    best_id   = `NO_INTERRUPT_SOURCE_ID;
    best_prio = {PRIO_W{1'b0}};
    for (k = 1; k <= NSRC; k = k + 1) begin
      if (pend_r[k] && enable_r[k] && prio_r[k] > best_prio) begin
        best_id   = k[7:0];
        best_prio = prio_r[k];
      end
    end
  end

  // Core id of a source; external ids sit just above the internal block
  function [7:0] core_id;
    input [7:0] src;
    begin
      if (src == `NO_INTERRUPT_SOURCE_ID)
        core_id = `NO_INTERRUPT_SOURCE_ID;
      else
        core_id = src + `LAST_INTERNAL_IRQ_ID;
    end
  endfunction

  // Completion decode
  wire [7:0] cmp_id  = pwdata[7:0];
  wire       cmp_ok  = pwdata[31:8] == 24'd0 && cmp_id != 8'h00 &&
                       cmp_id <= NSRC;
  wire       cmp_hit = wr_claim && cmp_ok && enable_r[cmp_id];
  wire       cmp_ign = wr_claim && !(cmp_ok && enable_r[cmp_id]);
  wire [7:0] pidx    = prio_index(paddr);

  // Per source gateway: one request in flight until completed
  genvar g;
  generate
    for (g = 1; g <= NSRC; g = g + 1) begin : gw
      wire claim_me = claim_go_r && access && claim_id_r == g;
      wire done_me  = cmp_hit && cmp_id == g;
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          pend_r[g] <= 1'b0;
          busy_r[g] <= 1'b0;
          prio_r[g] <= {PRIO_W{1'b0}};
        end else if (ce) begin
          // A level held high while busy cannot pend again until completion
          // claim clears pending
          if (claim_me)
            pend_r[g] <= 1'b0;
          else if (src_level[g] && !busy_r[g])
            pend_r[g] <= 1'b1;
          if (claim_me)
            busy_r[g] <= 1'b1;
          else if (done_me)
            busy_r[g] <= 1'b0;
          if (wr_acc && pidx == g)
            prio_r[g] <= pwdata[PRIO_W-1:0];
        end
      end
    end
  endgenerate

  // Events for the controller's own interrupt
  // Arrival counts only enabled sources that are free to pend
  wire [`EV_W-1:0] ev;
  assign ev[`EV_ARRIVE_BIT] = |(src_level & ~pend_r & ~busy_r & enable_r);
  assign ev[`EV_IGNORE_BIT] = cmp_ign;
  assign ev[`EV_EMPTY_BIT]  = claim_go_r & access & (claim_id_r == `NO_INTERRUPT_SOURCE_ID);

  reg [31:0] rd_nxt;
  reg [31:0] en_word;
  reg [31:0] pend_word;
  always @* begin
    en_word   = 32'h0000_0000;
    pend_word = 32'h0000_0000;
    en_word[NSRC:1]   = enable_r;
    pend_word[NSRC:1] = pend_r;
    rd_nxt = 32'h0000_0000;
    if (pidx != 8'h00)
      rd_nxt[PRIO_W-1:0] = prio_r[pidx];
    else begin
      case (paddr)
        `ENABLE_OFS:  rd_nxt = en_word;
        `PENDING_OFS: rd_nxt = pend_word;
        `THRESH_OFS:  rd_nxt[PRIO_W-1:0] = thresh_r;
        `CLAIM_OFS:   rd_nxt[7:0] = best_id;
        `SOFT_OFS:    rd_nxt[`SOFT_FLAG_BIT] = soft_irq_r;
        `TVEC_OFS:    rd_nxt = trap_vector_r;
        `ISTAT_OFS:   rd_nxt[`EV_W-1:0] = istat_r;
        `IEN_OFS:     rd_nxt[`EV_W-1:0] = ien_r;
        // Clear register and holes read as zero
        default:      rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Bus answer registered at setup, so access phase lasts one cycle when ce is high at setup; with ce low there pready never rises
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready     <= 1'b0;
      prdata     <= 32'h0000_0000;
      pslverr    <= 1'b0;
      claim_id_r <= 8'h00;
      claim_go_r <= 1'b0;
    end else if (ce) begin
      if (setup) begin
        pready     <= 1'b1;
        pslverr    <= !mapped(paddr) || (pwrite && paddr == `PENDING_OFS) ||
                      (!pwrite && paddr == `ICLR_OFS);
        prdata     <= pwrite ? 32'h0000_0000 : rd_nxt;
        // Id frozen here so the one returned is the one cleared
        claim_id_r <= best_id;
        claim_go_r <= !pwrite && paddr == `CLAIM_OFS;
      end else if (access) begin
        pready     <= 1'b0;
        pslverr    <= 1'b0;
        claim_go_r <= 1'b0;
      end
    end
  end

  // Software registers
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      enable_r      <= {NSRC{1'b0}};
      thresh_r      <= {PRIO_W{1'b0}};
      soft_irq_r    <= 1'b0;
      trap_vector_r <= `TVEC_RST;
      ien_r         <= {`EV_W{1'b0}};
      istat_r       <= {`EV_W{1'b0}};
    end else if (ce) begin
      // Enable bit 0 unused: source zero means no interrupt
      // per source enable
      if (wr_enable)
        enable_r <= pwdata[NSRC:1];
      if (wr_thresh)
        thresh_r <= pwdata[PRIO_W-1:0];
      if (wr_soft)
        soft_irq_r <= pwdata[`SOFT_FLAG_BIT];
      if (wr_tvec)
        trap_vector_r <= pwdata;

      // Controller's own interrupt enables
      if (wr_ien)
        ien_r <= pwdata[`EV_W-1:0];

      // New events win over a clear in the same cycle
      if (wr_iclr)
        istat_r <= (istat_r & ~pwdata[`EV_W-1:0]) | ev;
      else
        istat_r <= istat_r | ev;
    end
  end

  // Hart facing outputs
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ext_irq_r    <= 1'b0;
      ext_irq_id_r <= `NO_INTERRUPT_SOURCE_ID;
      timer_irq_r  <= 1'b0;
      ctrl_irq_r   <= 1'b0;
    end else if (ce) begin
      // Threshold gates only the request line, never the claim
      // strictly above threshold
      ext_irq_r    <= best_id != `NO_INTERRUPT_SOURCE_ID && best_prio > thresh_r;
      ext_irq_id_r <= core_id(best_id);
      // timer compare line, fixed internal id
      timer_irq_r  <= timer_cmp_level;
      ctrl_irq_r   <= |(istat_r & ien_r);
    end
  end

endmodule // plic_core

/* File: common/plic_defs.vh */
// Register offsets, field positions, reset values and interrupt ids of the controller
`ifndef PLIC_DEFS_VH
`define PLIC_DEFS_VH
`define PRIO_BASE      12'h000
`define ENABLE_OFS     12'h100
`define PENDING_OFS    12'h140
`define THRESH_OFS     12'h200
`define CLAIM_OFS      12'h204
`define SOFT_OFS       12'h300
`define TVEC_OFS       12'h304
`define ISTAT_OFS      12'h310
`define ICLR_OFS       12'h314
`define IEN_OFS        12'h318
`define SOFT_FLAG_BIT  0
`define EV_ARRIVE_BIT  0
`define EV_IGNORE_BIT  1
`define EV_EMPTY_BIT   2
`define EV_W           3
`define TVEC_RST       32'h0000_0000
`define TIMER_SOFTWARE_IRQ_ID    8'h03
`define TIMER_COMPARE_IRQ_ID     8'h07
`define LAST_INTERNAL_IRQ_ID     8'h12
`define NO_INTERRUPT_SOURCE_ID   8'h00
`define FIRST_EXTERNAL_SOURCE_ID 8'h13
`endif

/* File: verification/plic_src_model.sv */
// Peripheral and timer interrupt lines feeding the controller
`timescale 1ns/100ps
module plic_src_model #(parameter NSRC = 31) (
  // Clock and reset
  input  wire logic            clk, rstn,
  // Requests from the bench
  input  wire logic [NSRC:1]   want,
  input  wire logic            tmr_want,
  // Lines to the controller
  output logic      [NSRC:1]   src_level,
  output logic                 timer_cmp_level
);
  // Lines change only after an edge, as a real peripheral would
  always @(posedge clk or negedge rstn)
    if (!rstn) {src_level, timer_cmp_level} <= '0;
    else {src_level, timer_cmp_level} <= {want, tmr_want};
endmodule // plic_src_model

/* File: verification/plic_core_chk.sv */
// Port checker for the interrupt controller
`timescale 1ns/100ps
`include "plic_defs.vh"
module plic_chk #(parameter NSRC = 31) (
  input wire logic clk, rstn, ce, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata, trap_vector_r,
  input wire logic timer_cmp_level, ext_irq_r, soft_irq_r, timer_irq_r,
  input wire logic [7:0] ext_irq_id_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire acc = psel && penable && pready;
  wire wr = acc && pwrite;
  wire cl = acc && !pwrite && paddr == `CLAIM_OFS && !pslverr;
  wire w0 = pwdata[0];
  answer_a: assert property (ce && psel && !penable |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");
  claim_range_a: assert property (cl |-> prdata <= NSRC)
    else $error("claim id out of range");
  claim_twice_a: assert property (cl && prdata != 0 ##2 cl |-> prdata != $past(prdata, 2))
    else $error("same source claimed twice");
  soft_flag_a: assert property (wr && paddr == `SOFT_OFS |=> soft_irq_r == $past(w0))
    else $error("soft flag not written");
  trap_vec_a: assert property (wr && paddr == `TVEC_OFS |=> trap_vector_r == $past(pwdata))
    else $error("trap vector not written");
  timer_copy_a: assert property ($past(rstn) && $past(ce) |-> timer_irq_r == $past(timer_cmp_level))
    else $error("timer request lost");
  ext_first_a: assert property (ext_irq_r |-> ext_irq_id_r >= `FIRST_EXTERNAL_SOURCE_ID)
    else $error("external id too low");
  id_internal_a: assert property (ext_irq_id_r != 0 |-> ext_irq_id_r > `LAST_INTERNAL_IRQ_ID)
    else $error("internal id used");
  no_zero_a: assert property (ext_irq_r |-> ext_irq_id_r != `NO_INTERRUPT_SOURCE_ID)
    else $error("request with empty id");
  err_data_a: assert property (pready && pslverr && !pwrite |-> prdata == 0)
    else $error("refused read returned data");
  cover property (cl && prdata != 0);
  cover property (ext_irq_r);
  cover property (pready && pslverr);
endmodule // plic_chk
bind plic_core plic_chk #(.NSRC(NSRC)) chk (.*);

/* File: verification/platform_interrupt_controller_tb_top.sv */
// Self-checking bench for the interrupt controller
`timescale 1ns/100ps
`include "plic_defs.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected at %0t: %h vs %h", $time, g, e); end end
module platform_interrupt_controller_tb_top;
  logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, tmr_want = 0, ce = 1;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, trap_vector_r, tv;
  logic pready, pslverr, ext_irq_r, soft_irq_r, timer_irq_r, ctrl_irq_r, timer_cmp_level;
  logic [7:0] ext_irq_id_r;
  logic [31:1] want = 0, src_level;
  logic [33:0] q[$], n;
  int miscompares = 0, checked = 0;
  plic_core DUT (.*);
  plic_src_model M (.*);
  initial forever #4 clk = ~clk;
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic c, logic [31:0] x, logic e);
    q.push_back({c, e, x});
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk) penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] x, logic e = 0); apb(0, a, 0, 1, x, e); endtask
  task automatic wr(logic [11:0] a, logic [31:0] d); apb(1, a, d, 0, 0, 0); endtask
  task automatic idle(int k); psel <= 0; penable <= 0; repeat (k) @(posedge clk); endtask
  // Refusal flag checked on every access, data on reads
  always @(posedge clk) if (psel && penable && pready === 1'b1) begin
    n = q.pop_front();
    `CHK(pslverr, n[32])
    if (n[33]) `CHK(prdata, n[31:0])
  end
  task automatic end_of_test;
    if (miscompares == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin #200000; miscompares++; end_of_test; end
  initial begin
    void'($urandom(32'h451a2ff8));
    repeat (12) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    rd(`THRESH_OFS, 0);
    rd(`ENABLE_OFS, 0);
    rd(12'h080, 0, 1);
    rd(`ICLR_OFS, 0, 1);
    apb(1, `PENDING_OFS, 1, 0, 0, 1);
    tv = $urandom;
    wr(`TVEC_OFS, tv);
    rd(`TVEC_OFS, tv);
    tv = $urandom_range(7);
    wr(`THRESH_OFS, tv);
    rd(`THRESH_OFS, tv);
    for (int s = 4; s > 0; s--) begin
      tv = $urandom_range(7, 1);
      wr(12'(4 * s), tv);
      rd(12'(4 * s), tv);
      wr(12'(4 * s), (s == 2 || s == 3) ? 5 : 3 - s / 2);
    end
    wr(`SOFT_OFS, 1);
    idle(1);
    `CHK(soft_irq_r, 1'b1)
    wr(`THRESH_OFS, 7);
    wr(`ICLR_OFS, 7);
    wr(`IEN_OFS, 4);
    rd(`CLAIM_OFS, 0);
    idle(3);
    `CHK(ctrl_irq_r, 1'b1)
    wr(`IEN_OFS, 0);
    idle(3);
    `CHK(ctrl_irq_r, 1'b0)
    wr(`ENABLE_OFS, 32'h1e);
    want <= 31'h0f;
    tmr_want <= 1;
    idle(5);
    `CHK(ext_irq_r, 1'b0)
    `CHK(ext_irq_id_r, 8'd20)
    rd(`CLAIM_OFS, 2);
    rd(`CLAIM_OFS, 3);
    rd(`CLAIM_OFS, 1);
    rd(`CLAIM_OFS, 4);
    rd(`CLAIM_OFS, 0);
    ce <= 0;
    tmr_want <= 0;
    idle(3);
    `CHK(timer_irq_r, 1'b1)
    ce <= 1;
    want <= 31'h04;
    tmr_want <= 0;
    wr(`THRESH_OFS, 4);
    wr(`CLAIM_OFS, 3);
    idle(4);
    `CHK(ext_irq_r, 1'b1)
    `CHK(ext_irq_id_r, 8'd21)
    wr(`THRESH_OFS, 5);
    idle(3);
    `CHK(ext_irq_r, 1'b0)
    wr(`ENABLE_OFS, 32'h1c);
    wr(`ICLR_OFS, 7);
    wr(`CLAIM_OFS, 1);
    want <= 31'h05;
    wr(`ENABLE_OFS, 32'h1e);
    idle(3);
    rd(`ISTAT_OFS, 2);
    rd(`CLAIM_OFS, 3);
    rd(`CLAIM_OFS, 0);
    idle(2);
    end_of_test;
  end
endmodule // platform_interrupt_controller_tb_top
